// file: hdl/angle_sensor_register_map.v
// Register map of the rotary angle sensor, driven by decoded serial frames

`include "angle_sensor_defines.vh"

module angle_sensor_register_map (
   // Clock and reset
   input  wire                  clk_i,
   input  wire                  reset_n_i,
   // Decoded frames from the serial front end
   input  wire                  frame_valid_i,
   input  wire [15:0]           frame_data_i,
   input  wire                  frame_error_i,
   output wire [15:0]           resp_data_o,
   // Measurement inputs
   input  wire [7:0]            gain_value_i,
   input  wire                  cordic_overflow_i,
   input  wire                  offset_loop_done_i,
   input  wire [13:0]           magnitude_i,
   input  wire [13:0]           raw_angle_i,
   input  wire [13:0]           comp_angle_i,
   // Programmed OTP array contents
   input  wire [7:0]            otp_zero_high_i,
   input  wire [7:0]            otp_zero_low_i,
   input  wire [7:0]            otp_settings_a_i,
   input  wire [7:0]            otp_settings_b_i,
   input  wire [4:0]            otp_redundancy_i,
   // OTP programming control
   output wire                  otp_write_enable_o,
   output wire                  otp_verify_select_o,
   output wire                  otp_burn_start_o,
   output wire                  otp_reload_o,
   // Configuration towards the output generators
   output wire [13:0]           zero_position_o,
   output wire                  noise_setting_o,
   output wire                  direction_o,
   output wire                  output_arrangement_select_o,
   output wire                  incremental_active_o,
   output wire                  commutation_active_o,
   output wire                  pwm_on_w_pin_o,
   output wire                  pwm_on_i_pin_o,
   output wire                  incremental_binary_select_o,
   output wire [7:0]            settings_b_o,
   output wire [4:0]            redundancy_o,
   output wire [13:0]           angle_out_o,
   output wire                  system_error_o
);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   localparam ST_CMD  = 1'b0;
   localparam ST_DATA = 1'b1;
   // Slots of the four stored programming bits
   localparam P_EN     = 0;
   localparam P_RELOAD = 1;
   localparam P_BURN   = 2;
   localparam P_VERIFY = 3;

   reg                  state_reg;
   reg                  state_next;
   reg  [13:0]          waddr_reg;
   reg  [13:0]          waddr_next;
   reg  [2:0]           err_reg;
   reg  [2:0]           err_next;
   reg  [3:0]           otp_program_control_reg;
   reg  [3:0]           otp_program_control_next;
   reg  [7:0]           zhigh_reg;
   reg  [7:0]           zhigh_next;
   reg  [7:0]           zlow_reg;
   reg  [7:0]           zlow_next;
   reg  [7:0]           seta_reg;
   reg  [7:0]           seta_next;
   reg  [7:0]           setb_reg;
   reg  [7:0]           setb_next;
   reg  [4:0]           red_reg;
   reg  [4:0]           red_next;
   reg  [15:0]          resp_reg;
   reg  [15:0]          resp_next;
   reg                  burn_reg;
   reg                  burn_next;
   reg                  reload_reg;
   reg                  reload_next;

   // -------------------------------------------------------------------------
   // Register views
   // -------------------------------------------------------------------------
   wire                 gain_max = (gain_value_i == `GAIN_MAX_VALUE);
   wire                 gain_min = (gain_value_i == `GAIN_MIN_VALUE);
   reg  [13:0]          diag_view;
   reg  [13:0]          otp_program_control_view;
   reg  [13:0]          seta_view;
   wire [13:0]          comp_angle;

   // Views are built bit by bit so each field lands where the map puts it
   always @* begin
      diag_view = 14'h0000;
      diag_view[`GAIN_W-1:0]         = gain_value_i;
      diag_view[`DIAG_LOOP_DONE_BIT] = offset_loop_done_i;
      diag_view[`DIAG_COF_BIT]       = cordic_overflow_i;
      diag_view[`DIAG_GAIN_MIN_BIT]  = gain_min;
      diag_view[`DIAG_GAIN_MAX_BIT]  = gain_max;
   end

   always @* begin
      otp_program_control_view = 14'h0000;
      otp_program_control_view[`OTP_PROGRAM_CONTROL_WRITE_EN_BIT] = otp_program_control_reg[P_EN];
      otp_program_control_view[`OTP_PROGRAM_CONTROL_RELOAD_BIT]   = otp_program_control_reg[P_RELOAD];
      otp_program_control_view[`OTP_PROGRAM_CONTROL_BURN_BIT]     = otp_program_control_reg[P_BURN];
      otp_program_control_view[`OTP_PROGRAM_CONTROL_VERIFY_BIT]   = otp_program_control_reg[P_VERIFY];
   end

   // Factory bit is hard-wired; the stored copy of bit 0 is never read
   always @* begin
      seta_view = {6'h00, seta_reg};
      seta_view[`SETA_FACTORY_BIT] = 1'b1;
   end
   // With compensation off the compensated path simply repeats the raw angle
   assign comp_angle = seta_reg[`SETA_COMP_DIS_BIT] ? raw_angle_i : comp_angle_i;

   // -------------------------------------------------------------------------
   // Read decode
   // -------------------------------------------------------------------------
   reg  [13:0]          rd_data;
   reg                  addr_ok;
   wire [13:0]          frame_addr = frame_data_i[`ADDR_W-1:0];
   // A pending write decodes its stored address, so its data frame sees the target
   wire [13:0]          dec_addr   = (state_reg == ST_DATA) ? waddr_reg : frame_addr;

   always @* begin
      rd_data = 14'h0000;
      addr_ok = 1'b1;
      case (dec_addr)
         `ADDR_NO_OPERATION:  rd_data = 14'h0000;
         `ADDR_ERROR_FLAGS:   rd_data = {11'h000, err_reg};
         `ADDR_OTP_OTP_PROGRAM_CONTROL_CTRL: rd_data = otp_program_control_view;
         `ADDR_ZERO_POS_HIGH: rd_data = {6'h00, zhigh_reg};
         `ADDR_ZERO_POS_LOW:  rd_data = {6'h00, zlow_reg};
         `ADDR_SETTINGS_A:    rd_data = seta_view;
         `ADDR_SETTINGS_B:    rd_data = {6'h00, setb_reg};
         `ADDR_REDUNDANCY:    rd_data = {9'h000, red_reg};
         `ADDR_DIAG_GAIN:     rd_data = diag_view;
         `ADDR_MAGNITUDE:     rd_data = magnitude_i;
         `ADDR_ANGLE_UNCOMP:  rd_data = raw_angle_i;
         `ADDR_ANGLE_COMP: begin
            rd_data = seta_reg[`SETA_DATASEL_BIT] ? raw_angle_i : comp_angle;
         end
         default: begin
            addr_ok = 1'b0;
         end
      endcase
   end

   // -------------------------------------------------------------------------
   // Frame handling
   // -------------------------------------------------------------------------
   wire                 parity_ok  = ~(^frame_data_i);
   wire                 is_read    = frame_data_i[`FRAME_RW_BIT];
   wire [13:0]          payload    = frame_data_i[`DATA_W-1:0];
   // Error answer: EF set, data zero, parity bit keeps the word even
   wire [15:0]          err_resp   = {1'b1, 1'b1, 14'h0000};
   wire [15:0]          rd_resp    = {^rd_data, 1'b0, rd_data};
   wire [15:0]          echo_resp  = {^payload, 1'b0, payload};
   // Read-only targets accept the data frame but keep their contents
   wire                 ro_target  = (waddr_reg == `ADDR_NO_OPERATION) |
                                     (waddr_reg == `ADDR_ERROR_FLAGS) |
                                     (waddr_reg == `ADDR_DIAG_GAIN) |
                                     (waddr_reg == `ADDR_MAGNITUDE) |
                                     (waddr_reg == `ADDR_ANGLE_UNCOMP) |
                                     (waddr_reg == `ADDR_ANGLE_COMP);

   always @* begin
      state_next  = state_reg;
      waddr_next  = waddr_reg;
      err_next    = err_reg;
      otp_program_control_next   = otp_program_control_reg;
      zhigh_next  = zhigh_reg;
      zlow_next   = zlow_reg;
      seta_next   = seta_reg;
      setb_next   = setb_reg;
      red_next    = red_reg;
      resp_next   = resp_reg;
      burn_next   = 1'b0;
      reload_next = 1'b0;
      if (frame_error_i) begin
         // Abandon any half-done write; the next frame is a command again
         state_next = ST_CMD;
         err_next[`ERR_FRAMING_BIT] = 1'b1;
         resp_next = err_resp;
      end else if (frame_valid_i) begin
         case (state_reg)
            ST_CMD: begin
               if (!parity_ok) begin
                  err_next[`ERR_PARITY_BIT] = 1'b1;
                  resp_next = err_resp;
               end else if (!addr_ok) begin
                  err_next[`ERR_INVALID_CMD_BIT] = 1'b1;
                  resp_next = err_resp;
               end else if (is_read) begin
                  resp_next = rd_resp;
                  // Read clears every flag; this frame raises none, so none survives
                  if (frame_addr == `ADDR_ERROR_FLAGS) begin
                     err_next = `ERR_RESET;
                  end
                  // Address zero falls through with no side effect
               end else begin
                  // Old contents go back in the next frame
                  waddr_next = frame_addr;
                  state_next = ST_DATA;
                  resp_next  = rd_resp;
               end
            end
            ST_DATA: begin
               state_next = ST_CMD;
               if (!parity_ok) begin
                  err_next[`ERR_PARITY_BIT] = 1'b1;
                  resp_next = err_resp;
               end else begin
                  // Read-only targets echo what they really hold
                  resp_next = ro_target ? rd_resp : echo_resp;
                  case (waddr_reg)
                     `ADDR_OTP_OTP_PROGRAM_CONTROL_CTRL: begin
                        otp_program_control_next = {frame_data_i[`OTP_PROGRAM_CONTROL_VERIFY_BIT],
                                     frame_data_i[`OTP_PROGRAM_CONTROL_BURN_BIT],
                                     frame_data_i[`OTP_PROGRAM_CONTROL_RELOAD_BIT],
                                     frame_data_i[`OTP_PROGRAM_CONTROL_WRITE_EN_BIT]};
                        // Burn needs the enable, old or just written
                        burn_next = frame_data_i[`OTP_PROGRAM_CONTROL_BURN_BIT] &
                                    (frame_data_i[`OTP_PROGRAM_CONTROL_WRITE_EN_BIT] |
                                     otp_program_control_reg[P_EN]);
                        reload_next = frame_data_i[`OTP_PROGRAM_CONTROL_RELOAD_BIT];
                        if (frame_data_i[`OTP_PROGRAM_CONTROL_RELOAD_BIT]) begin
                           zhigh_next = otp_zero_high_i;
                           zlow_next  = otp_zero_low_i;
                           seta_next  = otp_settings_a_i;
                           setb_next  = otp_settings_b_i;
                           red_next   = otp_redundancy_i;
                        end
                     end
                     `ADDR_ZERO_POS_HIGH: zhigh_next = frame_data_i[`NV_W-1:0];
                     `ADDR_ZERO_POS_LOW:  zlow_next  = frame_data_i[`NV_W-1:0];
                     `ADDR_SETTINGS_A:    seta_next  = frame_data_i[`NV_W-1:0];
                     `ADDR_SETTINGS_B:    setb_next  = frame_data_i[`NV_W-1:0];
                     `ADDR_REDUNDANCY:    red_next   = frame_data_i[`RED_W-1:0];
                     default: begin
                        // Read-only targets store nothing
                        state_next = ST_CMD;
                     end
                  endcase
               end
            end
            default: begin
               state_next = ST_CMD;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_reg  <= ST_CMD;
         waddr_reg  <= 14'h0000;
         err_reg    <= `ERR_RESET;
         otp_program_control_reg   <= 4'h0;
         zhigh_reg  <= `NV_RESET;
         zlow_reg   <= `NV_RESET;
         seta_reg   <= `NV_RESET;
         setb_reg   <= `NV_RESET;
         red_reg    <= `RED_RESET;
         resp_reg   <= 16'h0000;
         burn_reg   <= 1'b0;
         reload_reg <= 1'b0;
      end else begin
         state_reg  <= state_next;
         waddr_reg  <= waddr_next;
         err_reg    <= err_next;
         otp_program_control_reg   <= otp_program_control_next;
         zhigh_reg  <= zhigh_next;
         zlow_reg   <= zlow_next;
         seta_reg   <= seta_next;
         setb_reg   <= setb_next;
         red_reg    <= red_next;
         resp_reg   <= resp_next;
         burn_reg   <= burn_next;
         reload_reg <= reload_next;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign resp_data_o                 = resp_reg;
   assign otp_write_enable_o          = otp_program_control_reg[P_EN];
   assign otp_verify_select_o         = otp_program_control_reg[P_VERIFY];
   assign otp_burn_start_o            = burn_reg;
   assign otp_reload_o                = reload_reg;
   assign zero_position_o             = {zhigh_reg, zlow_reg[5:0]};
   assign noise_setting_o             = seta_reg[`SETA_NOISE_BIT];
   assign direction_o                 = seta_reg[`SETA_DIR_BIT];
   assign output_arrangement_select_o = seta_reg[`SETA_ARRANGE_BIT];
   assign incremental_active_o        = ~seta_reg[`SETA_ARRANGE_BIT];
   assign commutation_active_o        = seta_reg[`SETA_ARRANGE_BIT];
   assign pwm_on_w_pin_o              = seta_reg[`SETA_PWM_EN_BIT] &
                                        ~seta_reg[`SETA_ARRANGE_BIT];
   assign pwm_on_i_pin_o              = seta_reg[`SETA_PWM_EN_BIT] &
                                        seta_reg[`SETA_ARRANGE_BIT];
   assign incremental_binary_select_o = seta_reg[`SETA_BINARY_BIT];
   assign settings_b_o                = setb_reg;
   assign redundancy_o                = red_reg;
   assign angle_out_o                 = comp_angle;
   // Overflow always counts; the gain extremes only when their enable is set
   assign system_error_o              = cordic_overflow_i |
                                        (gain_max & zlow_reg[`ZPOS_EN_GMAX_BIT]) |
                                        (gain_min & zlow_reg[`ZPOS_EN_GMIN_BIT]);

endmodule

// file: hdl/angle_sensor_defines.vh
// Constants for the angle sensor register map block
`ifndef ANGLE_SENSOR_DEFINES_VH
`define ANGLE_SENSOR_DEFINES_VH

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define FRAME_W              16
`define ADDR_W               14
`define DATA_W               14
`define FRAME_PARITY_BIT     15
`define FRAME_RW_BIT         14
`define FRAME_EF_BIT         14

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define ADDR_NO_OPERATION    14'h0000
`define ADDR_ERROR_FLAGS     14'h0001
`define ADDR_OTP_OTP_PROGRAM_CONTROL_CTRL   14'h0003
`define ADDR_ZERO_POS_HIGH   14'h0016
`define ADDR_ZERO_POS_LOW    14'h0017
`define ADDR_SETTINGS_A      14'h0018
`define ADDR_SETTINGS_B      14'h0019
`define ADDR_REDUNDANCY      14'h001A
`define ADDR_DIAG_GAIN       14'h3FFC
`define ADDR_MAGNITUDE       14'h3FFD
`define ADDR_ANGLE_UNCOMP    14'h3FFE
`define ADDR_ANGLE_COMP      14'h3FFF

// ----------------------------------------------------------------------------
// Error flag bits
// ----------------------------------------------------------------------------
`define ERR_FRAMING_BIT      0
`define ERR_INVALID_CMD_BIT  1
`define ERR_PARITY_BIT       2
`define ERR_W                3

// ----------------------------------------------------------------------------
// Programming control bits
// ----------------------------------------------------------------------------
`define OTP_PROGRAM_CONTROL_WRITE_EN_BIT    0
`define OTP_PROGRAM_CONTROL_RELOAD_BIT      2
`define OTP_PROGRAM_CONTROL_BURN_BIT        3
`define OTP_PROGRAM_CONTROL_VERIFY_BIT      6

// ----------------------------------------------------------------------------
// Diagnostic register bits
// ----------------------------------------------------------------------------
`define DIAG_GAIN_MAX_BIT    11
`define DIAG_GAIN_MIN_BIT    10
`define DIAG_COF_BIT         9
`define DIAG_LOOP_DONE_BIT   8
`define GAIN_W               8
`define GAIN_MAX_VALUE       8'hFF
`define GAIN_MIN_VALUE       8'h00

// ----------------------------------------------------------------------------
// Non-volatile register fields
// ----------------------------------------------------------------------------
`define NV_W                 8
`define RED_W                5
`define ZPOS_LOW_W           6
`define ZPOS_EN_GMAX_BIT     6
`define ZPOS_EN_GMIN_BIT     7
`define SETA_FACTORY_BIT     0
`define SETA_NOISE_BIT       1
`define SETA_DIR_BIT         2
`define SETA_ARRANGE_BIT     3
`define SETA_COMP_DIS_BIT    4
`define SETA_BINARY_BIT      5
`define SETA_DATASEL_BIT     6
`define SETA_PWM_EN_BIT      7
`define NV_RESET             8'h00
`define RED_RESET            5'h00
`define ERR_RESET            3'h0

`endif

// file: verification/angle_sensor_register_map_monitor.sv
// Concurrent checks on the ports of the angle sensor register map
module angle_sensor_register_map_monitor (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // Frame port
   input  wire logic        frame_valid_i,
   input  wire logic [15:0] frame_data_i,
   input  wire logic        frame_error_i,
   input  wire logic [15:0] resp_data_o,
   // Measurements and programmed contents
   input  wire logic [7:0]  gain_value_i,
   input  wire logic [13:0] raw_angle_i,
   input  wire logic [7:0]  otp_zero_high_i,
   input  wire logic [7:0]  otp_zero_low_i,
   // Programming and configuration outputs
   input  wire logic        otp_write_enable_o,
   input  wire logic        otp_burn_start_o,
   input  wire logic        otp_reload_o,
   input  wire logic [13:0] zero_position_o
);
   timeunit 1ns / 1ps;
   // ------------
   // Frame decode
   // ------------
   // Data frames of a write are not commands; the phase is tracked as the map does
   logic       data_ph;
   wire        good_w = frame_valid_i & ~frame_error_i & ~(^frame_data_i);
   wire        cmd_w  = good_w & ~data_ph;
   wire        rd_w   = cmd_w & frame_data_i[14];
   wire [13:0] a_w    = frame_data_i[13:0];
   wire        map_w  = (a_w < 14'h0004 && a_w != 14'h0002) || a_w >= 14'h3FFC
                        || (a_w >= 14'h0016 && a_w <= 14'h001A);
   always @(posedge clk_i) begin
      if (!reset_n_i || frame_error_i) begin
         data_ph <= 1'b0;
      end else if (frame_valid_i) begin
         data_ph <= cmd_w & ~frame_data_i[14] & map_w;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   // ----------
   // Assertions
   // ----------
   burn_needs_enable_a: assert property (otp_burn_start_o |->
      otp_write_enable_o || $past(otp_write_enable_o))
      else $error("burn pulse without write enable");
   burn_single_pulse_a: assert property ($rose(otp_burn_start_o) |=> !otp_burn_start_o)
      else $error("burn pulse longer than one cycle");
   reload_loads_zero_a: assert property (otp_reload_o |->
      zero_position_o[13:6] == $past(otp_zero_high_i)
      && {2'h0, zero_position_o[5:0]} == ($past(otp_zero_low_i) & 8'h3F))
      else $error("zero position not loaded on reload");
   parity_flagged_a: assert property (frame_valid_i && !frame_error_i && ^frame_data_i
      |=> resp_data_o[14])
      else $error("bad parity not flagged");
   framing_flagged_a: assert property (frame_error_i |=> resp_data_o[14])
      else $error("framing error not flagged");
   nop_read_quiet_a: assert property (rd_w && a_w == 14'h0000
      |=> resp_data_o == 16'h0000 && $stable(zero_position_o))
      else $error("no-operation read had an effect");
   unmapped_flagged_a: assert property (cmd_w && !map_w
      |=> resp_data_o[14] && resp_data_o[13:0] == 14'h0000)
      else $error("unmapped access not flagged");
   raw_angle_read_a: assert property (rd_w && a_w == 14'h3FFE
      |=> resp_data_o[13:0] == $past(raw_angle_i))
      else $error("raw angle read wrong");
   gain_status_read_a: assert property (rd_w && a_w == 14'h3FFC |=>
      resp_data_o[7:0] == $past(gain_value_i) && resp_data_o[11] == ($past(gain_value_i) == 8'hFF)
      && resp_data_o[10] == ($past(gain_value_i) == 8'h00))
      else $error("gain status read wrong");
   burn_seen_c: cover property (otp_burn_start_o);
   reload_seen_c: cover property (otp_reload_o);
   unmapped_seen_c: cover property (cmd_w && !map_w);
endmodule

// file: verification/host_master_model.sv
// Host model that hands decoded command and data frames to the register map
module host_master_model (
   // Clock
   input  wire logic        clk_i,
   // Frames towards the register map
   output logic             frame_valid_o,
   output logic [15:0]      frame_data_o,
   output logic             frame_error_o
);
   timeunit 1ns / 1ps;
   initial begin
      frame_valid_o = 1'b0;
      frame_data_o  = 16'h0000;
      frame_error_o = 1'b0;
   end
   // Body is the read flag and 14-bit address or data; gap slows the host down
   task automatic xfer(input logic [14:0] body, input logic bad_par, input logic err,
                       input int gap);
      @(negedge clk_i);
      frame_data_o  <= {^body ^ bad_par, body};
      frame_valid_o <= ~err;
      frame_error_o <= err;
      @(negedge clk_i);
      frame_valid_o <= 1'b0;
      frame_error_o <= 1'b0;
      // Stale word inverted so nothing can lean on it
      frame_data_o  <= ~{^body ^ bad_par, body};
      repeat (gap) @(negedge clk_i);
   endtask
endmodule

// file: verification/angle_sensor_register_map_tb.sv
// Self-checking bench for the angle sensor register map
module angle_sensor_register_map_tb;
   timeunit 1ns / 1ps;
   logic        clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   wire         frame_valid_i, frame_error_i;
   wire  [15:0] frame_data_i, resp_data_o;
   logic [7:0]  gain_value_i = 8'hFF;
   logic        cordic_overflow_i = 1'b1;
   logic        offset_loop_done_i = 1'b1;
   logic [13:0] magnitude_i = 14'h2A5C;
   logic [13:0] raw_angle_i = 14'h1234;
   logic [13:0] comp_angle_i = 14'h0ABC;
   logic [7:0]  otp_zero_high_i = 8'h5A;
   logic [7:0]  otp_zero_low_i = 8'h3C;
   logic [7:0]  otp_settings_a_i = 8'h40;
   logic [7:0]  otp_settings_b_i = 8'h21;
   logic [4:0]  otp_redundancy_i = 5'h13;
   wire         otp_write_enable_o, otp_verify_select_o, otp_burn_start_o, otp_reload_o;
   wire         noise_setting_o, direction_o, output_arrangement_select_o, system_error_o;
   wire         incremental_active_o, commutation_active_o, pwm_on_w_pin_o, pwm_on_i_pin_o;
   wire         incremental_binary_select_o;
   wire  [13:0] zero_position_o, angle_out_o;
   wire  [7:0]  settings_b_o;
   wire  [4:0]  redundancy_o;
   wire  [7:0]  cfg_w = {incremental_binary_select_o, direction_o, noise_setting_o,
                         output_arrangement_select_o, commutation_active_o,
                         incremental_active_o, pwm_on_i_pin_o, pwm_on_w_pin_o};
   logic [13:0] set_val [4] = '{14'h0051, 14'h0089, 14'h0081, 14'h0027};
   logic [7:0]  cfg_exp [4] = '{8'h00, 8'h1A, 8'h05, 8'hE4};
   logic [13:0] reg_addr [7] = '{14'h0001, 14'h0003, 14'h0016, 14'h0017, 14'h0018, 14'h0019,
                                 14'h001A};
   logic [13:0] reg_rst [7] = '{14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0001, 14'h0000,
                                14'h0000};
   int          mismatches = 0;
   int          n_compared = 0;
   int          cyc = 0;

   host_master_model mdl_u (.clk_i(clk_i), .frame_valid_o(frame_valid_i),
                            .frame_data_o(frame_data_i), .frame_error_o(frame_error_i));
   angle_sensor_register_map dut_u (.*);

   always #5 clk_i = ~clk_i;

   // -----------------
   // Checks and access
   // -----------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Response word with even parity over all 16 bits
   function automatic logic [15:0] mk(input logic ef, input logic [13:0] d);
      return {^{ef, d}, ef, d};
   endfunction
   task automatic rd(input logic [13:0] a, input logic [15:0] exp);
      mdl_u.xfer({1'b1, a}, 1'b0, 1'b0, 1);
      chk(resp_data_o, exp);
   endtask
   task automatic wr(input logic [13:0] a, input logic [13:0] old, input logic [13:0] nw);
      mdl_u.xfer({1'b0, a}, 1'b0, 1'b0, 0);
      chk(resp_data_o, mk(1'b0, old));
      mdl_u.xfer({1'b0, nw}, 1'b0, 1'b0, 0);
      chk(resp_data_o, mk(1'b0, nw));
   endtask
   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // A run needs under two hundred cycles; the ceiling leaves ample margin
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         final_report();
      end
   end

   initial begin
      repeat (16) @(negedge clk_i);
      reset_n_i = 1'b1;
      foreach (reg_addr[i]) rd(reg_addr[i], mk(1'b0, reg_rst[i]));
      rd(14'h3FFC, mk(1'b0, 14'h0BFF));
      gain_value_i = 8'h00;
      cordic_overflow_i = 1'b0;
      offset_loop_done_i = 1'b0;
      rd(14'h3FFC, mk(1'b0, 14'h0400));
      rd(14'h3FFD, mk(1'b0, magnitude_i));
      rd(14'h3FFE, mk(1'b0, raw_angle_i));
      rd(14'h3FFF, mk(1'b0, comp_angle_i));
      chk(angle_out_o, comp_angle_i);
      wr(14'h0003, 14'h0000, 14'h0008);
      chk(otp_burn_start_o, 1'b0);
      wr(14'h0018, 14'h0001, set_val[0]);
      rd(14'h3FFF, mk(1'b0, raw_angle_i));
      chk(angle_out_o, raw_angle_i);
      for (int i = 1; i < 4; i++) begin
         wr(14'h0018, set_val[i - 1], set_val[i]);
         chk(cfg_w, cfg_exp[i]);
      end
      rd(14'h3FFF, mk(1'b0, comp_angle_i));
      wr(14'h0016, 14'h0000, 14'h00AB);
      wr(14'h0017, 14'h0000, 14'h00C5);
      chk(zero_position_o, {8'hAB, 6'h05});
      chk(system_error_o, 1'b1);
      wr(14'h0017, 14'h00C5, 14'h0045);
      chk(system_error_o, 1'b0);
      gain_value_i = 8'hFF;
      @(negedge clk_i);
      chk(system_error_o, 1'b1);
      wr(14'h0019, 14'h0000, 14'h00C3);
      wr(14'h001A, 14'h0000, 14'h0015);
      chk({settings_b_o, redundancy_o}, {8'hC3, 5'h15});
      mdl_u.xfer({1'b0, 14'h3FFD}, 1'b0, 1'b0, 0);
      mdl_u.xfer({1'b0, 14'h1111}, 1'b0, 1'b0, 0);
      chk(resp_data_o, mk(1'b0, magnitude_i));
      rd(14'h3FFD, mk(1'b0, magnitude_i));
      rd(14'h0002, mk(1'b1, 14'h0000));
      rd(14'h0001, mk(1'b0, 14'h0002));
      rd(14'h0001, mk(1'b0, 14'h0000));
      mdl_u.xfer({1'b1, 14'h3FFE}, 1'b1, 1'b0, 0);
      chk(resp_data_o, mk(1'b1, 14'h0000));
      mdl_u.xfer(15'h7FFF, 1'b0, 1'b1, 2);
      chk(resp_data_o, mk(1'b1, 14'h0000));
      rd(14'h0000, mk(1'b0, 14'h0000));
      rd(14'h0001, mk(1'b0, 14'h0005));
      mdl_u.xfer({1'b0, 14'h0020}, 1'b0, 1'b0, 0);
      chk(resp_data_o, mk(1'b1, 14'h0000));
      rd(14'h3FFE, mk(1'b0, raw_angle_i));
      rd(14'h0001, mk(1'b0, 14'h0002));
      wr(14'h0003, 14'h0008, 14'h0001);
      chk(otp_write_enable_o, 1'b1);
      wr(14'h0003, 14'h0001, 14'h0009);
      chk(otp_burn_start_o, 1'b1);
      wr(14'h0003, 14'h0009, 14'h0040);
      chk(otp_verify_select_o, 1'b1);
      wr(14'h0003, 14'h0040, 14'h0004);
      chk(otp_reload_o, 1'b1);
      chk(zero_position_o, 14'h16BC);
      chk({settings_b_o, redundancy_o}, {8'h21, 5'h13});
      rd(14'h0018, mk(1'b0, 14'h0041));
      rd(14'h3FFF, mk(1'b0, raw_angle_i));
      final_report();
   end
endmodule

bind angle_sensor_register_map angle_sensor_register_map_monitor mon_u (.*);
